/* File: hdl/ckid_defines.svh */
// ckid_defines.svh - addresses, bit positions, reset values and timing of the
// carkit uart / id detect register block
// assumes inclusion by bare name from the package and the design modules
`ifndef CKID_DEFINES_SVH
`define CKID_DEFINES_SVH

// ----------------------------------------------------------------------------
// register addresses (read at any of base..base+2, write base, set +1, clear +2)
// ----------------------------------------------------------------------------
`define CKID_ADDR_W          6
`define CKID_ADDR_CTRL_WR    6'h19
`define CKID_ADDR_CTRL_SET   6'h1a
`define CKID_ADDR_CTRL_CLR   6'h1b
`define CKID_ADDR_IEN_WR     6'h1d
`define CKID_ADDR_IEN_SET    6'h1e
`define CKID_ADDR_IEN_CLR    6'h1f
`define CKID_ADDR_STATUS     6'h20
`define CKID_ADDR_LATCH      6'h21
`define CKID_ADDR_CONV_WR    6'h36
`define CKID_ADDR_CONV_SET   6'h37
`define CKID_ADDR_CONV_CLR   6'h38

// ----------------------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------------------
`define CKID_CTRL_MASK       8'h0e
`define CKID_CTRL_RESET      8'h00
`define CKID_IEN_MASK        8'h23
`define CKID_IEN_RESET       8'h00
`define CKID_CONV_MASK       8'h57
`define CKID_CONV_RESET      8'h00
`define CKID_LATCH_RESET     8'h00
`define CKID_BYTE_ZERO       8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CKID_CTRL_ID_GND     1
`define CKID_CTRL_TX_EN      2
`define CKID_CTRL_RX_EN      3
`define CKID_IEN_OPEN_RISE   0
`define CKID_IEN_OPEN_FALL   1
`define CKID_IEN_CONV        5
`define CKID_STAT_OPEN       0
`define CKID_STAT_CODE_LO    3
`define CKID_STAT_DONE       6
`define CKID_LATCH_OPEN      0
`define CKID_LATCH_CONV      3
`define CKID_CONV_CODE_LO    0
`define CKID_CONV_DONE       3
`define CKID_CONV_START      4
`define CKID_CONV_IRQ_EN     6
`define CKID_CODE_W          3

// ----------------------------------------------------------------------------
// timing: conversion time in microseconds and clock rate in MHz
// ----------------------------------------------------------------------------
`define CKID_CONV_TIME_US    282
`define CKID_CLK_MHZ         250
`define CKID_CONV_CYCLES     (`CKID_CONV_TIME_US * `CKID_CLK_MHZ)

`endif

/* File: hdl/ckid_pkg.sv */
// ckid_pkg - types shared by the carkit uart / id detect register block
// assumes ckid_defines.svh is on the include path
package ckid_pkg;
   `include "ckid_defines.svh"

   typedef logic [7:0] ckid_byte_type;
   typedef logic [`CKID_ADDR_W-1:0] ckid_addr_type;

   // resistor converter sequencer states
   typedef enum logic [0:0] {
      CKID_CONV_IDLE = 1'b0,
      CKID_CONV_BUSY = 1'b1
   } ckid_conv_state_type;
endpackage : ckid_pkg

/* File: hdl/ckid_sync.sv */
// ckid_sync - two flip-flop synchroniser for a bundle of pin levels
// assumes each bit is an independent level from outside the clk_i domain
`timescale 1ns/1ps
module ckid_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   import ckid_pkg::*;

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // first stage is read only by the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;
endmodule : ckid_sync

/* File: hdl/ckid_conv_timer.sv */
// ckid_conv_timer - times one id resistor conversion
// assumes start_i is a level held until finish_o; result sampled by the caller
`timescale 1ns/1ps
`include "ckid_defines.svh"
module ckid_conv_timer #(
   parameter int CYCLES = `CKID_CONV_CYCLES
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic start_i,
   output logic      busy_o,
   output logic      finish_o
);
   import ckid_pkg::*;

   localparam int CW = $clog2(CYCLES + 1);

   ckid_conv_state_type state_ff;
   ckid_conv_state_type nxt_state;
   logic [CW-1:0]       count_ff;
   logic [CW-1:0]       nxt_count;
   logic                finish_ff;
   logic                nxt_finish;

   // sequencer: idle until start, then count the conversion time
   always_comb begin
      nxt_state  = state_ff;
      nxt_count  = count_ff;
      nxt_finish = 1'b0;
      case (state_ff)
         CKID_CONV_IDLE: begin
            if (start_i) begin
               nxt_state = CKID_CONV_BUSY;
               nxt_count = CW'(CYCLES - 1);
            end
         end
         CKID_CONV_BUSY: begin
            if (count_ff == '0) begin
               nxt_state  = CKID_CONV_IDLE;
               nxt_finish = 1'b1;
            end else begin
               nxt_count = count_ff - 1'b1;
            end
         end
         default: begin
            nxt_state = CKID_CONV_IDLE;
         end
      endcase
   end

   // state registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff  <= CKID_CONV_IDLE;
         count_ff  <= '0;
         finish_ff <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         count_ff  <= nxt_count;
         finish_ff <= nxt_finish;
      end
   end

   assign busy_o   = (state_ff == CKID_CONV_BUSY) | finish_ff;
   assign finish_o = finish_ff;
endmodule : ckid_conv_timer

/* File: hdl/ckid_regs.sv */
// ckid_regs - carkit uart routing and id detect register block of the phy
// assumes a decoded link register port on clk_i (one access per strobe),
// uart_mode_i from the interface control register on the same clock, and
// pin levels (id open, d+, link data 0, resistor code) asynchronous to clk_i
`timescale 1ns/1ps
`include "ckid_defines.svh"

// Function
// - data line 1 high when receive route off
// - route control read/write/set/clear at 19h-1Bh
// - control bit 1 grounds the id pin
// - control bit 2 routes data 0 to d-
// - control bit 3 routes d+ to data 1
// - irq enable read/write/set/clear at 1Dh-1Fh
// - enable bit 0: alt interrupt on id opening
// - enable bit 1: alt interrupt on id closing
// - unimplemented detect and d+ fields read zero
// - enable bit 5 or vendor enable: conversion interrupt
// - status at 20h, bit 0 id open
// - status bits 5:3 carry resistor code
// - status bit 6 set after 282us conversion
// - done clears only on vendor register read
// - latch register at 21h clears on read
// - latch bit 0 on enabled id edge
// - latch bit 3 on enabled done rise
// - start bit 4 begins conversion, self-clears
module ckid_regs #(
   parameter int CONV_CYCLES = `CKID_CONV_CYCLES
) (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire ckid_pkg::ckid_addr_type reg_addr_i,
   input  wire logic                    reg_wr_i,
   input  wire ckid_pkg::ckid_byte_type reg_wdata_i,
   input  wire logic                    reg_rd_i,
   output ckid_pkg::ckid_byte_type      reg_rdata_o,
   output logic                         reg_rvalid_o,
   output logic                         alt_int_o,
   input  wire logic                    uart_mode_i,
   input  wire logic                    link_data0_i,
   output logic                         link_data1_o,
   output logic                         link_data1_oe_o,
   input  wire logic                    dplus_i,
   output logic                         dminus_o,
   output logic                         dminus_oe_o,
   output logic                         id_pin_ground_drive_o,
   input  wire logic                    id_open_i,
   input  wire logic [2:0]              id_resistor_code_i
);
   import ckid_pkg::*;

   // -------------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------------
   logic [5:0] pins_async;
   logic [5:0] pins_sync;
   logic       id_open_s;
   logic       dplus_s;
   logic       data0_s;
   logic [2:0] code_s;

   // every pin is named directly so any change re-evaluates the bundle
   assign pins_async = {id_resistor_code_i, link_data0_i, dplus_i, id_open_i};

   ckid_sync #(
      .WIDTH   (6)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (pins_async),
      .sync_o  (pins_sync)
   );

   assign id_open_s = pins_sync[0];
   assign dplus_s   = pins_sync[1];
   assign data0_s   = pins_sync[2];
   assign code_s    = pins_sync[5:3];

   // -------------------------------------------------------------------------
   // access decode
   // -------------------------------------------------------------------------
   logic ctrl_wr, ctrl_set, ctrl_clr;
   logic ien_wr, ien_set, ien_clr;
   logic conv_wr, conv_set, conv_clr;
   logic conv_rd, latch_rd;

   // write, set and clear strobes per register
   assign ctrl_wr  = reg_wr_i & (reg_addr_i == `CKID_ADDR_CTRL_WR);
   assign ctrl_set = reg_wr_i & (reg_addr_i == `CKID_ADDR_CTRL_SET);
   assign ctrl_clr = reg_wr_i & (reg_addr_i == `CKID_ADDR_CTRL_CLR);
   assign ien_wr   = reg_wr_i & (reg_addr_i == `CKID_ADDR_IEN_WR);
   assign ien_set  = reg_wr_i & (reg_addr_i == `CKID_ADDR_IEN_SET);
   assign ien_clr  = reg_wr_i & (reg_addr_i == `CKID_ADDR_IEN_CLR);
   assign conv_wr  = reg_wr_i & (reg_addr_i == `CKID_ADDR_CONV_WR);
   assign conv_set = reg_wr_i & (reg_addr_i == `CKID_ADDR_CONV_SET);
   assign conv_clr = reg_wr_i & (reg_addr_i == `CKID_ADDR_CONV_CLR);
   assign conv_rd  = reg_rd_i & (reg_addr_i >= `CKID_ADDR_CONV_WR)
                              & (reg_addr_i <= `CKID_ADDR_CONV_CLR);
   assign latch_rd = reg_rd_i & (reg_addr_i == `CKID_ADDR_LATCH);

   // write/set/clear update of a byte, limited to its writable bits
   function automatic ckid_byte_type wsc(input ckid_byte_type cur,
                                         input ckid_byte_type data,
                                         input ckid_byte_type mask,
                                         input logic wr, input logic set,
                                         input logic clr);
      ckid_byte_type res;
      res = cur;
      if (wr) begin
         res = data;
      end else if (set) begin
         res = cur | data;
      end else if (clr) begin
         res = cur & ~data;
      end
      wsc = (res & mask) | (cur & ~mask);
   endfunction : wsc

   // -------------------------------------------------------------------------
   // route control and interrupt enable registers
   // -------------------------------------------------------------------------
   ckid_byte_type ctrl_ff, nxt_ctrl;
   ckid_byte_type ien_ff, nxt_ien;

   // only bits 1..3 and 0,1,5 are storage; the rest stay zero
   always_comb begin
      nxt_ctrl = wsc(ctrl_ff, reg_wdata_i, `CKID_CTRL_MASK,
                     ctrl_wr, ctrl_set, ctrl_clr);
      nxt_ien  = wsc(ien_ff, reg_wdata_i, `CKID_IEN_MASK,
                     ien_wr, ien_set, ien_clr);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= `CKID_CTRL_RESET;
         ien_ff  <= `CKID_IEN_RESET;
      end else begin
         ctrl_ff <= nxt_ctrl;
         ien_ff  <= nxt_ien;
      end
   end

   // -------------------------------------------------------------------------
   // resistor conversion register and sequencer
   // -------------------------------------------------------------------------
   ckid_byte_type conv_ff, nxt_conv;
   logic          conv_busy, conv_finish;
   logic          conv_irq_en;

   ckid_conv_timer #(
      .CYCLES   (CONV_CYCLES)
   ) u_conv (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .start_i  (conv_ff[`CKID_CONV_START] & ~conv_busy),
      .busy_o   (conv_busy),
      .finish_o (conv_finish)
   );

   // software fields update, done and start follow the converter
   always_comb begin
      nxt_conv = wsc(conv_ff, reg_wdata_i, `CKID_CONV_MASK,
                     conv_wr, conv_set, conv_clr);
      nxt_conv[`CKID_CONV_DONE] = conv_ff[`CKID_CONV_DONE] & ~conv_rd;
      if (conv_finish) begin
         nxt_conv[`CKID_CONV_CODE_LO +: `CKID_CODE_W] = code_s;
         nxt_conv[`CKID_CONV_DONE]  = 1'b1;
         nxt_conv[`CKID_CONV_START] = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conv_ff <= `CKID_CONV_RESET;
      end else begin
         conv_ff <= nxt_conv;
      end
   end

   assign conv_irq_en = ien_ff[`CKID_IEN_CONV] | conv_ff[`CKID_CONV_IRQ_EN];

   // -------------------------------------------------------------------------
   // event detection, latch and alternate interrupt
   // -------------------------------------------------------------------------
   logic          id_open_prev_ff, done_prev_ff;
   logic          open_rise, open_fall, done_rise;
   logic          id_evt, conv_evt;
   ckid_byte_type latch_ff, nxt_latch;
   logic          alt_int_ff, nxt_alt_int;

   assign open_rise = id_open_s & ~id_open_prev_ff;
   assign open_fall = ~id_open_s & id_open_prev_ff;
   assign done_rise = conv_ff[`CKID_CONV_DONE] & ~done_prev_ff;
   assign id_evt    = (open_rise & ien_ff[`CKID_IEN_OPEN_RISE])
                    | (open_fall & ien_ff[`CKID_IEN_OPEN_FALL]);
   assign conv_evt  = done_rise & conv_irq_en;

   // latch clears on read, a same-cycle event is kept
   always_comb begin
      nxt_latch = latch_rd ? `CKID_LATCH_RESET : latch_ff;
      if (id_evt) begin
         nxt_latch[`CKID_LATCH_OPEN] = 1'b1;
      end
      if (conv_evt) begin
         nxt_latch[`CKID_LATCH_CONV] = 1'b1;
      end
      nxt_alt_int = id_evt | conv_evt;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         id_open_prev_ff <= 1'b0;
         done_prev_ff    <= 1'b0;
         latch_ff        <= `CKID_LATCH_RESET;
         alt_int_ff      <= 1'b0;
      end else begin
         id_open_prev_ff <= id_open_s;
         done_prev_ff    <= conv_ff[`CKID_CONV_DONE];
         latch_ff        <= nxt_latch;
         alt_int_ff      <= nxt_alt_int;
      end
   end

   assign alt_int_o = alt_int_ff;

   // -------------------------------------------------------------------------
   // read path
   // -------------------------------------------------------------------------
   ckid_byte_type status_val, rd_val;
   ckid_byte_type rdata_ff, nxt_rdata;
   logic          rvalid_ff, nxt_rvalid;

   // status view: id open, code and done; fields 1,2,7 zero
   always_comb begin
      status_val = `CKID_BYTE_ZERO;
      status_val[`CKID_STAT_OPEN] = id_open_s;
      status_val[`CKID_STAT_CODE_LO +: `CKID_CODE_W] =
         conv_ff[`CKID_CONV_CODE_LO +: `CKID_CODE_W];
      status_val[`CKID_STAT_DONE] = conv_ff[`CKID_CONV_DONE];
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      case (reg_addr_i)
         `CKID_ADDR_CTRL_WR, `CKID_ADDR_CTRL_SET, `CKID_ADDR_CTRL_CLR: begin
            rd_val = ctrl_ff;
         end
         `CKID_ADDR_IEN_WR, `CKID_ADDR_IEN_SET, `CKID_ADDR_IEN_CLR: begin
            rd_val = ien_ff;
         end
         `CKID_ADDR_STATUS: begin
            rd_val = status_val;
         end
         `CKID_ADDR_LATCH: begin
            rd_val = latch_ff;
         end
         `CKID_ADDR_CONV_WR, `CKID_ADDR_CONV_SET, `CKID_ADDR_CONV_CLR: begin
            rd_val = conv_ff;
         end
         default: begin
            rd_val = `CKID_BYTE_ZERO;
         end
      endcase
      nxt_rdata  = reg_rd_i ? rd_val : rdata_ff;
      nxt_rvalid = reg_rd_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_ff  <= `CKID_BYTE_ZERO;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff  <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   assign reg_rdata_o  = rdata_ff;
   assign reg_rvalid_o = rvalid_ff;

   // -------------------------------------------------------------------------
   // uart routing and id ground drive
   // -------------------------------------------------------------------------
   logic data1_ff, nxt_data1, data1_oe_ff, nxt_data1_oe;
   logic dm_ff, nxt_dm, dm_oe_ff, nxt_dm_oe;
   logic id_gnd_ff, nxt_id_gnd;

   // route bits act once uart mode is selected; link sets them first
   always_comb begin
      nxt_data1    = ctrl_ff[`CKID_CTRL_RX_EN] ? dplus_s : 1'b1;
      nxt_data1_oe = uart_mode_i;
      nxt_dm       = data0_s;
      nxt_dm_oe    = uart_mode_i & ctrl_ff[`CKID_CTRL_TX_EN];
      nxt_id_gnd   = ctrl_ff[`CKID_CTRL_ID_GND];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data1_ff    <= 1'b1;
         data1_oe_ff <= 1'b0;
         dm_ff       <= 1'b0;
         dm_oe_ff    <= 1'b0;
         id_gnd_ff   <= 1'b0;
      end else begin
         data1_ff    <= nxt_data1;
         data1_oe_ff <= nxt_data1_oe;
         dm_ff       <= nxt_dm;
         dm_oe_ff    <= nxt_dm_oe;
         id_gnd_ff   <= nxt_id_gnd;
      end
   end

   assign link_data1_o          = data1_ff;
   assign link_data1_oe_o       = data1_oe_ff;
   assign dminus_o              = dm_ff;
   assign dminus_oe_o           = dm_oe_ff;
   assign id_pin_ground_drive_o = id_gnd_ff;
endmodule : ckid_regs

/* File: tb/ckid_regs_props.sv */
// ckid_regs_props - port checker for the carkit uart / id detect registers
// assumes a bind onto ckid_regs, one clock, synchronous active-high reset
`timescale 1ns/1ps
module ckid_regs_props (
   input wire logic                    clk_i,
   input wire logic                    rst_i,
   input wire ckid_pkg::ckid_addr_type reg_addr_i,
   input wire logic                    reg_wr_i,
   input wire ckid_pkg::ckid_byte_type reg_wdata_i,
   input wire logic                    reg_rd_i,
   input wire ckid_pkg::ckid_byte_type reg_rdata_o,
   input wire logic                    reg_rvalid_o,
   input wire logic                    alt_int_o,
   input wire logic                    uart_mode_i,
   input wire logic                    link_data1_o,
   input wire logic                    dminus_oe_o,
   input wire logic                    id_pin_ground_drive_o
);
   import ckid_pkg::*;
   ckid_byte_type ctl_ff, nxt_ctl, ien_ff, nxt_ien, ven_ff, nxt_ven;
   logic [1:0]    quiet_ff, nxt_quiet;
   logic          mode_ff;

   // shadow of one write / set / clear triple
   function automatic ckid_byte_type upd(input ckid_byte_type r, input ckid_addr_type b,
                                         input ckid_byte_type m);
      ckid_byte_type d;
      d = reg_wdata_i & m;
      upd = r;
      if (reg_wr_i && reg_addr_i == b) upd = d;
      if (reg_wr_i && reg_addr_i == b + 6'h01) upd = r | d;
      if (reg_wr_i && reg_addr_i == b + 6'h02) upd = r & ~d;
   endfunction : upd

   // next shadows; quiet counts settled cycles since a write or mode change
   always_comb begin
      nxt_ctl = upd(ctl_ff, 6'h19, 8'h0e);
      nxt_ien = upd(ien_ff, 6'h1d, 8'h23);
      nxt_ven = upd(ven_ff, 6'h36, 8'h40);
      nxt_quiet = (quiet_ff == 2'h3) ? 2'h3 : quiet_ff + 2'h1;
      if (reg_wr_i || uart_mode_i != mode_ff) nxt_quiet = 2'h0;
   end

   // shadow registers
   always_ff @(posedge clk_i) begin
      ctl_ff   <= rst_i ? 8'h00 : nxt_ctl;
      ien_ff   <= rst_i ? 8'h00 : nxt_ien;
      ven_ff   <= rst_i ? 8'h00 : nxt_ven;
      quiet_ff <= rst_i ? 2'h0 : nxt_quiet;
      mode_ff  <= uart_mode_i;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_rd(lo, hi);
      reg_rd_i && reg_addr_i >= lo && reg_addr_i <= hi;
   endsequence

   property p_rvalid; reg_rd_i |=> reg_rvalid_o; endproperty
   a_rvalid: assert property (p_rvalid) else $error("read not answered");
   property p_ctl_read; s_rd(6'h19, 6'h1b) |=> reg_rdata_o == ctl_ff; endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("route control read");
   property p_ien_read; s_rd(6'h1d, 6'h1f) |=> reg_rdata_o == ien_ff; endproperty
   a_ien_read: assert property (p_ien_read) else $error("irq enable read");
   property p_zero_bits; s_rd(6'h20, 6'h21) |=> (reg_rdata_o & 8'h86) == 8'h00; endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("unused bits set");
   property p_id_drive; quiet_ff == 2'h3 |-> id_pin_ground_drive_o == ctl_ff[1]; endproperty
   a_id_drive: assert property (p_id_drive) else $error("id drive wrong");
   property p_rx_off; quiet_ff == 2'h3 && !ctl_ff[3] |-> link_data1_o; endproperty
   a_rx_off: assert property (p_rx_off) else $error("data 1 not high");
   property p_tx_oe; quiet_ff == 2'h3 && uart_mode_i == mode_ff |->
      dminus_oe_o == (uart_mode_i && ctl_ff[2]); endproperty
   a_tx_oe: assert property (p_tx_oe) else $error("d- enable wrong");
   property p_alt_cause; alt_int_o |-> (|(ien_ff & 8'h23)) || ven_ff[6]; endproperty
   a_alt_cause: assert property (p_alt_cause) else $error("unenabled alt int");
endmodule : ckid_regs_props

bind ckid_regs ckid_regs_props i_ckid_regs_props (
   .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .reg_rvalid_o(reg_rvalid_o), .alt_int_o(alt_int_o), .uart_mode_i(uart_mode_i),
   .link_data1_o(link_data1_o), .dminus_oe_o(dminus_oe_o),
   .id_pin_ground_drive_o(id_pin_ground_drive_o));

/* File: tb/ckid_link_model.sv */
// ckid_link_model - link side of the carkit uart pins
// assumes the bench reports when the route bits have been programmed
`timescale 1ns/1ps
module ckid_link_model (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic routes_set_i,
   input  wire logic enter_i,
   input  wire logic tx_bit_i,
   output logic      uart_mode_o,
   output logic      link_data0_o
);
   logic mode_ff, nxt_mode;

   // uart mode is only entered once the route bits are in place
   always_comb begin
      nxt_mode = mode_ff;
      if (!enter_i) nxt_mode = 1'b0;
      else if (routes_set_i) nxt_mode = 1'b1;
   end

   // mode register
   always_ff @(posedge clk_i) begin
      mode_ff <= rst_i ? 1'b0 : nxt_mode;
   end

   // transmit line idles high outside uart mode
   assign uart_mode_o  = mode_ff;
   assign link_data0_o = mode_ff ? tx_bit_i : 1'b1;
endmodule : ckid_link_model

/* File: tb/testbench.sv */
// testbench - register-access tests of the carkit uart / id detect block
// assumes ckid_regs, its checker bind and the link model are compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module testbench;
   import ckid_pkg::*;
   localparam int CONV = 20;
   localparam logic [5:0] RA [6] = '{6'h19, 6'h1b, 6'h1d, 6'h20, 6'h21, 6'h3f};
   localparam logic [2:0] CODES [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
   logic          clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   ckid_addr_type reg_addr_i = 6'h00;
   ckid_byte_type reg_wdata_i = 8'h00, reg_rdata_o;
   logic          reg_rvalid_o, alt_int_o, uart_mode_i, link_data0_i, link_data1_o;
   logic          link_data1_oe_o, dminus_o, dminus_oe_o, id_pin_ground_drive_o;
   logic          dplus_i = 1'b0, id_open_i = 1'b0, routes_set = 1'b0, enter = 1'b0;
   logic          tx_bit = 1'b1;
   logic [2:0]    id_resistor_code_i = 3'h0;
   int            bad_count = 0, checks = 0;

   ckid_regs #(.CONV_CYCLES(CONV)) i_ckid_regs (
      .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .alt_int_o(alt_int_o), .uart_mode_i(uart_mode_i),
      .link_data0_i(link_data0_i), .link_data1_o(link_data1_o),
      .link_data1_oe_o(link_data1_oe_o), .dplus_i(dplus_i), .dminus_o(dminus_o),
      .dminus_oe_o(dminus_oe_o), .id_pin_ground_drive_o(id_pin_ground_drive_o),
      .id_open_i(id_open_i), .id_resistor_code_i(id_resistor_code_i));
   ckid_link_model i_ckid_link_model (
      .clk_i(clk_i), .rst_i(rst_i), .routes_set_i(routes_set), .enter_i(enter),
      .tx_bit_i(tx_bit), .uart_mode_o(uart_mode_i), .link_data0_o(link_data0_i));

   // 250 MHz clock
   always #2 clk_i = ~clk_i;

   // verdict and end of run
   task automatic summarize();
      if (bad_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize

   // let n edges pass, then settle just after the last
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick

   // one write strobe, then an idle cycle
   task automatic wr(input ckid_addr_type a, input ckid_byte_type d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      tick(1);
      reg_wr_i = 1'b0;
      tick(1);
   endtask : wr

   // one read strobe; answer is checked in the following cycle
   task automatic rd(input ckid_addr_type a, input ckid_byte_type e, input string n);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      tick(1);
      reg_rd_i = 1'b0;
      `CHK("rvalid", 1'b1, reg_rvalid_o)
      `CHK(n, e, reg_rdata_o)
      tick(1);
   endtask : rd

   // bounded watch for the alternate interrupt pulse
   task automatic expect_alt(input logic want);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 60 && !(want && seen); i++) begin
         tick(1);
         if (alt_int_o === 1'b1) seen = 1'b1;
      end
      `CHK("alt_int", want, seen)
      if (want && !seen) summarize();
   endtask : expect_alt

   // main sequence
   initial begin
      tick(8);
      rst_i = 1'b0;
      foreach (RA[i]) rd(RA[i], 8'h00, "reset");
      // route control write, clear, set
      wr(6'h19, 8'hff);
      rd(6'h1a, 8'h0e, "ctl_wr");
      wr(6'h1b, 8'h04);
      rd(6'h1b, 8'h0a, "ctl_clr");
      wr(6'h1a, 8'h05);
      rd(6'h19, 8'h0e, "ctl_set");
      `CHK("id_drive", 1'b1, id_pin_ground_drive_o)
      wr(6'h19, 8'h04);
      tick(2);
      `CHK("id_release", 1'b0, id_pin_ground_drive_o)
      // uart mode with transmit route only, then receive route
      routes_set = 1'b1;
      enter = 1'b1;
      tick(5);
      `CHK("data1_idle", 1'b1, link_data1_o)
      `CHK("dminus_oe", 1'b1, dminus_oe_o)
      tx_bit = 1'b0;
      tick(5);
      `CHK("dminus_lo", 1'b0, dminus_o)
      tx_bit = 1'b1;
      tick(5);
      `CHK("dminus_hi", 1'b1, dminus_o)
      wr(6'h1a, 8'h08);
      tick(5);
      `CHK("data1_lo", 1'b0, link_data1_o)
      dplus_i = 1'b1;
      tick(5);
      `CHK("data1_hi", 1'b1, link_data1_o)
      enter = 1'b0;
      // id float edges, enabled and then masked; pull-up assumed on
      wr(6'h1d, 8'hff);
      rd(6'h1f, 8'h23, "ien_wr");
      wr(6'h1f, 8'h20);
      id_open_i = 1'b1;
      expect_alt(1'b1);
      rd(6'h20, 8'h01, "id_open");
      rd(6'h21, 8'h01, "latch_rise");
      rd(6'h21, 8'h00, "latch_clr");
      id_open_i = 1'b0;
      expect_alt(1'b1);
      rd(6'h21, 8'h01, "latch_fall");
      id_open_i = 1'b1;
      tick(2);
      rd(6'h21, 8'h00, "latch_race");
      rd(6'h21, 8'h01, "latch_kept");
      wr(6'h1f, 8'h03);
      id_open_i = 1'b0;
      expect_alt(1'b0);
      id_open_i = 1'b1;
      expect_alt(1'b0);
      rd(6'h21, 8'h00, "latch_off");
      // one conversion for every result code except 6
      wr(6'h1e, 8'h20);
      foreach (CODES[i]) begin
         id_resistor_code_i = CODES[i];
         wr(6'h37, 8'h10);
         expect_alt(1'b1);
         rd(6'h20, {2'h1, CODES[i], 3'h1}, "status");
         rd(6'h20, {2'h1, CODES[i], 3'h1}, "status_again");
         rd(6'h21, 8'h08, "latch_conv");
         rd(6'h38, {5'h01, CODES[i]}, "vendor");
         rd(6'h20, {2'h0, CODES[i], 3'h1}, "done_clr");
      end
      // conversion interrupt through the vendor enable alone
      wr(6'h1f, 8'h20);
      wr(6'h37, 8'h50);
      expect_alt(1'b1);
      rd(6'h21, 8'h08, "latch_ven");
      summarize();
   end
endmodule : testbench
